// [verilog/twi_pkg.sv]
// Shared constants for the two-wire register port and its master
package twi_pkg;
  localparam logic [3:0] addr_high_nibble = 4'h7;
  localparam logic [7:0] ptr_fifo         = 8'h00;
  localparam logic [7:0] ptr_autosleep    = 8'h06;
  localparam logic [7:0] ptr_last         = 8'h5b;
  localparam int         clk_hz           = 25000000;
  localparam int         timeout_ms       = 20;
  localparam int         timeout_cycles   = (clk_hz / 1000) * timeout_ms;
  localparam int         link_div_default = 4;
  localparam logic [7:0] reset_ptr        = 8'h00;

  // Pointer advance after each data byte
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    logic [7:0] r;
    r = p + 8'h01;
    if (p == ptr_fifo || p == ptr_autosleep) begin
      r = ptr_fifo;
    end else if (p == ptr_last) begin
      r = p;
    end
    return r;
  endfunction : next_ptr
endpackage : twi_pkg

// [verilog/twi_if.sv]
// Two-wire link between master and slave ends
`timescale 1ns/1ps
interface twi_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Pulled-up open-drain wires resolved from the enables
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport slave  (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe,
                  output sda_m_o, output sda_m_oe);
endinterface : twi_if

// [verilog/twi_slave.sv]
// Two-wire slave port with register pointer and bus timeout
// What this block does
// [R1] Master starts transfers and drives clock
// [R2] Data open-drain, clock input only
// [R3] START, address, command, data bytes, STOP
// [R4] Detect START and STOP while clock high
// [R5] One bit per clock, stable when high
// [R6] Ninth clock carries receiver acknowledge
// [R7] Slave acks writes; master acks reads
// [R8] Address 0111, strap bits, then zero
// [R9] Direction bit: low write, high read
// [R10] Watch for START plus own address
// [R11] Timeout aborts after 20 ms idle clock
// [R12] After timeout, wait for fresh START
// [R13] Software control enables bus timeout
// [R14] First written byte is command pointer
// [R15] Command then STOP only stores pointer
// [R16] First data byte goes to pointer
// [R17] Later bytes follow advancing pointer
// [R18] Reads start at stored pointer
// [R19] Pointer stays or wraps per address
// [R20] Timeout sets flag; read clears it
// [R21] No timeout while asleep
// [R22] Mismatch: no ack until next START
// [R23] No ack on read: release line
`timescale 1ns/1ps
module twi_slave
  import twi_pkg::*;
#(
  parameter int timeout_cnt = timeout_cycles
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Link
  twi_if.slave            bus,
  // Strap: 0 ground, 1 supply, 2 data, 3 clock
  input  wire logic [1:0] address_strap_pin,
  // Control and status
  input  wire logic       timeout_en,
  input  wire logic       sleep,
  input  wire logic       flag_read,
  output logic            timeout_flag,
  // Register file port
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_we,
  output logic            reg_re,
  input  wire logic [7:0] reg_rdata,
  output logic [7:0]      pointer
);
  initial begin
    if (timeout_cnt < 2) $error("timeout_cnt too small");
  end

  // State walk of one transaction:
  //   idle -> addr on start
  //   addr -> ack on match, wait on mismatch
  //   ack -> cmd or rd after the address byte
  //   cmd -> ack -> wr, then wr -> ack -> wr per data byte
  //   rd -> rack -> rd while the master acks, else wait
  // Stop or start override every state; timeout forces idle.
  // Codes give single-bit steps on the write path only for idle->addr and ack<->cmd; addr->ack, ack->wr and wr->ack change two bits.

  typedef enum logic [2:0] {
    st_idle = 3'b000, st_addr = 3'b001, st_cmd = 3'b011, st_wr = 3'b010,
    st_rd = 3'b110, st_ack = 3'b111, st_rack = 3'b101, st_wait = 3'b100
  } state_t;


  // Two flops per pin before any logic; a third stage finds edges.
  // Edge detectors reset to the idle level so no false edge follows reset.
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_q, sda_q;
  logic       scl_r, scl_f, start_ev, stop_ev;
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end
  assign scl_r    = ~scl_q & scl_sync_q[1];
  assign scl_f    = scl_q & ~scl_sync_q[1];
  assign start_ev = scl_q & scl_sync_q[1] & sda_q & ~sda_sync_q[1];  // R4
  assign stop_ev  = scl_q & scl_sync_q[1] & ~sda_q & sda_sync_q[1];  // R4

  // Strap value is used as given; no bus level is sampled
  logic [1:0] strap_v;
  always_comb begin
    strap_v = address_strap_pin;
  end
  logic [6:0] own_addr;
  assign own_addr = {addr_high_nibble, strap_v, 1'b0};  // R8

  state_t     st_q, st_d, ret_q, ret_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wd_q, wd_d;
  logic [3:0] bit_q, bit_d;
  logic       drv_q, drv_d, first_q, first_d, flag_q, flag_d;
  logic       we_d, re_d, we_q, re_q;
  logic [$clog2(timeout_cnt+1)-1:0] to_q, to_d;
  logic       to_hit;


  // Timeout reloads on every clock edge and while idle.
  // Limitation: counts system clocks, so the limit scales with clk_hz.
  assign to_hit = timeout_en & ~sleep & (st_q != st_idle) & (to_q == '0);  // R11 R13 R21

  // Next-state logic; flag set by a timeout wins over a same-cycle clear

  always_comb begin
    st_d = st_q; ret_d = ret_q; sh_d = sh_q; ptr_d = ptr_q; wd_d = wd_q;
    bit_d = bit_q; drv_d = drv_q; first_d = first_q; flag_d = flag_q;
    we_d = 1'b0; re_d = 1'b0;
    to_d = (scl_r | scl_f | st_q == st_idle) ? timeout_cnt[$bits(to_q)-1:0]
         : (to_q == '0 ? to_q : to_q - 1'b1);
    if (flag_read) flag_d = 1'b0;  // R20
    if (to_hit) begin
      st_d = st_idle;  // R11 R12
      drv_d = 1'b1;
      flag_d = 1'b1;  // R20
    end else if (start_ev) begin
      st_d = st_addr; bit_d = 4'h0; drv_d = 1'b1;  // R10
    end else if (stop_ev) begin
      st_d = st_idle; drv_d = 1'b1;  // R15
    end else begin
      case (st_q)
        st_addr, st_cmd, st_wr: begin
          if (scl_r) begin
            sh_d = {sh_q[6:0], sda_sync_q[1]};  // R5
            bit_d = bit_q + 4'h1;
          end
          if (scl_f && bit_q == 4'h8) begin
            ret_d = st_q;
            if (st_q == st_addr && sh_q[7:1] != own_addr) begin
              st_d = st_wait;  // R22
            end else begin
              st_d = st_ack; drv_d = 1'b0;  // R6 R7
              if (st_q == st_cmd) ptr_d = sh_q;  // R14
              if (st_q == st_wr) begin
                wd_d = sh_q; we_d = 1'b1;  // R16
              end
            end
          end
        end
        st_ack: if (scl_f) begin
          bit_d = 4'h0; drv_d = 1'b1;
          if (ret_q == st_addr && sh_q[0]) begin
            st_d = st_rd; re_d = 1'b1; first_d = 1'b1;  // R9 R18
          end else begin
            st_d = (ret_q == st_addr) ? st_cmd : st_wr;  // R3 R9
            if (ret_q == st_wr) ptr_d = next_ptr(ptr_q);  // R17 R19
          end
        end
        st_rd: begin
          if (first_q) begin
            sh_d = reg_rdata; first_d = 1'b0; drv_d = reg_rdata[7];
            bit_d = 4'h1;
          end else if (scl_f) begin
            if (bit_q == 4'h8) begin
              st_d = st_rack; drv_d = 1'b1; ptr_d = next_ptr(ptr_q);  // R18 R19
            end else begin
              drv_d = sh_q[7 - bit_q[2:0]]; bit_d = bit_q + 4'h1;  // R5
            end
          end
        end
        st_rack: begin
          if (scl_r) sh_d[0] = sda_sync_q[1];
          if (scl_f) begin
            if (sh_q[0]) st_d = st_wait;  // R23
            else begin
              st_d = st_rd; re_d = 1'b1; first_d = 1'b1;  // R7
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= st_idle; ret_q <= st_idle; sh_q <= 8'h00; ptr_q <= reset_ptr;
      wd_q <= 8'h00; bit_q <= 4'h0; drv_q <= 1'b1; first_q <= 1'b0;
      flag_q <= 1'b0; we_q <= 1'b0; re_q <= 1'b0; to_q <= '0;
    end else begin
      st_q <= st_d; ret_q <= ret_d; sh_q <= sh_d; ptr_q <= ptr_d;
      wd_q <= wd_d; bit_q <= bit_d; drv_q <= drv_d; first_q <= first_d;
      flag_q <= flag_d; we_q <= we_d; re_q <= re_d; to_q <= to_d;
    end
  end


  // Only ever pulls low; clock never driven
  assign bus.sda_s_o  = 1'b0;  // R2
  assign bus.sda_s_oe = ~drv_q;  // R2 R1
  assign timeout_flag = flag_q;
  assign reg_addr     = ptr_q;
  assign reg_wdata    = wd_q;
  assign reg_we       = we_q;
  assign reg_re       = re_q;
  assign pointer      = ptr_q;
endmodule : twi_slave

// [verilog/twi_master.sv]
// Two-wire master end: byte-level command port with two-entry buffer
`timescale 1ns/1ps
module twi_master
  import twi_pkg::*;
#(
  parameter int div = link_div_default
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Link
  twi_if.master           bus,
  // Command: start, stop, read flag, data
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_data,
  // Answer: data and acknowledge seen
  output logic            rsp_valid,
  input  wire logic       rsp_ready,
  output logic [7:0]      rsp_data,
  output logic            rsp_ack
);
  initial begin
    if (div < 2) $error("div too small");
  end

  typedef enum logic [2:0] {
    m_idle = 3'b000, m_start = 3'b001, m_bit = 3'b011, m_stop = 3'b010
  } mstate_t;

  logic [$clog2(div)-1:0] dv_q, dv_d;
  logic tick;
  assign tick = (dv_q == '0);

  logic [1:0] sda_s_q;
  always_ff @(posedge clk) begin
    if (rst) sda_s_q <= 2'b11;
    else sda_s_q <= {sda_s_q[0], bus.sda};
  end

  mstate_t st_q, st_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] n_q, n_d;
  logic [8:0] sh_q, sh_d;
  logic       rd_q, rd_d, stp_q, stp_d, scl_q, scl_d, sdo_q, sdo_d, load;
  // Two-entry answer buffer so a stalled receiver loses nothing
  logic [8:0] buf_q [2];
  logic [8:0] buf_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic       push;

  assign cmd_ready = (st_q == m_idle) & (cnt_q != 2'd2);
  assign load      = cmd_valid & cmd_ready;
  assign rsp_valid = cnt_q != 2'd0;
  assign rsp_data  = buf_q[0][8:1];
  assign rsp_ack   = ~buf_q[0][0];

  always_comb begin
    st_d = st_q; ph_d = ph_q; n_d = n_q; sh_d = sh_q; rd_d = rd_q; stp_d = stp_q;
    scl_d = scl_q; sdo_d = sdo_q; push = 1'b0;
    dv_d = tick ? div[$bits(dv_q)-1:0] - 1'b1 : dv_q - 1'b1;
    case (st_q)
      m_idle: if (load) begin
        // Ack slot always released: a read byte ends in a no-ack,
        // so the slave lets go of data before our stop
        sh_d = {cmd_read ? 8'hff : cmd_data, 1'b1};
        rd_d = cmd_read; stp_d = cmd_stop; n_d = 4'h0; ph_d = 2'd0;
        st_d = cmd_start ? m_start : m_bit;
      end
      m_start: if (tick) begin
        ph_d = ph_q + 2'd1;
        if (ph_q == 2'd0) begin sdo_d = 1'b1; scl_d = 1'b1; end
        if (ph_q == 2'd1) sdo_d = 1'b0;
        if (ph_q == 2'd2) begin scl_d = 1'b0; st_d = m_bit; ph_d = 2'd0; end
      end
      m_bit: if (tick) begin
        ph_d = ph_q + 2'd1;
        if (ph_q == 2'd0) sdo_d = sh_q[8];
        if (ph_q == 2'd1) scl_d = 1'b1;
        if (ph_q == 2'd2) sh_d = {sh_q[7:0], sda_s_q[1]};
        if (ph_q == 2'd3) begin
          scl_d = 1'b0; n_d = n_q + 4'h1;
          if (n_q == 4'h8) begin
            push = 1'b1;
            st_d = stp_q ? m_stop : m_idle; ph_d = 2'd0;
          end
        end
      end
      m_stop: if (tick) begin
        ph_d = ph_q + 2'd1;
        if (ph_q == 2'd0) sdo_d = 1'b0;
        if (ph_q == 2'd1) scl_d = 1'b1;
        if (ph_q == 2'd2) begin sdo_d = 1'b1; st_d = m_idle; end
      end
      default: st_d = m_idle;
    endcase
    buf_d = buf_q; cnt_d = cnt_q;
    if (rsp_valid && rsp_ready) begin
      buf_d[0] = buf_q[1]; cnt_d = cnt_d - 2'd1;
    end
    if (push) buf_d[cnt_d[0]] = sh_d;
    if (push) cnt_d = cnt_d + 2'd1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= m_idle; ph_q <= 2'd0; n_q <= 4'h0; sh_q <= 9'h000; rd_q <= 1'b0;
      stp_q <= 1'b0; scl_q <= 1'b1; sdo_q <= 1'b1; dv_q <= '0; cnt_q <= 2'd0;
      buf_q[0] <= 9'h000; buf_q[1] <= 9'h000;
    end else begin
      st_q <= st_d; ph_q <= ph_d; n_q <= n_d; sh_q <= sh_d; rd_q <= rd_d;
      stp_q <= stp_d; scl_q <= scl_d; sdo_q <= sdo_d; dv_q <= dv_d; cnt_q <= cnt_d;
      buf_q[0] <= buf_d[0]; buf_q[1] <= buf_d[1];
    end
  end

  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = ~scl_q;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = ~sdo_q;
endmodule : twi_master

// [tb/twi_asserts.sv]
// Checker for the shared two-wire link between the master and slave ends
`timescale 1ns/1ps
module twi_asserts #(
  parameter int div = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  logic       scl_q, sda_q, frame_q, frame_d;
  logic [8:0] hold_q, hold_d;
  logic       start_ev, stop_ev;

  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;

  always_comb begin
    frame_d = rst ? 1'b0 : (start_ev | (frame_q & ~stop_ev));
    hold_d  = (rst | ~sda_s_oe) ? 9'h000 : hold_q + 9'h001;
  end

  always_ff @(posedge clk) begin
    scl_q   <= scl;
    sda_q   <= sda;
    frame_q <= frame_d;
    hold_q  <= hold_d;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_slave_open_drain: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave data not open drain");
  a_clock_master_only: assert property (!scl |-> scl_oe)
    else $error("clock low without master");
  a_drive_on_low: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("slave pulled data while clock high");
  a_release_on_low: assert property ($fell(sda_s_oe) |-> !scl)
    else $error("slave released data while clock high");
  a_hold_while_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave data moved in clock high");
  a_drive_in_frame: assert property (sda_s_oe |-> frame_q)
    else $error("slave drove data outside a frame");
  a_stop_release: assert property (stop_ev |=> !sda_s_oe [*4])
    else $error("slave drove data after stop");
  a_idle_clock_high: assert property (!frame_q |-> scl)
    else $error("clock low on idle bus");
  a_hold_bounded: assert property (int'(hold_q) < 12 * 4 * div)
    else $error("slave held data low too long");
endmodule : twi_asserts

// [tb/two_wire_slave_register_port_tb.sv]
// Bench: master and slave ends on one link, a lone slave on a stalled link
`timescale 1ns/1ps
module two_wire_slave_register_port_tb;
  import twi_pkg::*;
  localparam int tmo = 200;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0, cmd_start = 1'b0, cmd_stop = 1'b0, cmd_read = 1'b0;
  logic       rsp_ready = 1'b0, timeout_en = 1'b0, sleep = 1'b0, flag_read = 1'b0;
  logic       cmd_ready, rsp_valid, rsp_ack, reg_we, flag2;
  logic [1:0] address_strap_pin = 2'h0;
  logic [7:0] cmd_data = 8'h00, reg_rdata = 8'h00, wr_n = 8'h00, wr_addr, wr_data;
  logic [7:0] rsp_data, reg_addr, reg_wdata, pointer;
  logic [2:0] tmo_case [3] = '{3'h5, 3'h0, 3'h6};
  int         n_mismatch = 0, num_checks = 0, cycles = 0;

  twi_if bus ();
  twi_if bus2 ();
  twi_master #(.div(4)) u_twi_master (.clk(clk), .rst(rst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .rsp_ack(rsp_ack));
  twi_slave #(.timeout_cnt(tmo)) u_twi_slave (.clk(clk), .rst(rst), .bus(bus),
    .address_strap_pin(address_strap_pin), .timeout_en(timeout_en), .sleep(sleep),
    .flag_read(flag_read), .timeout_flag(), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(), .reg_rdata(reg_rdata), .pointer(pointer));
  twi_slave #(.timeout_cnt(tmo)) u_twi_slave_b (.clk(clk), .rst(rst), .bus(bus2),
    .address_strap_pin(address_strap_pin), .timeout_en(timeout_en), .sleep(sleep),
    .flag_read(flag_read), .timeout_flag(flag2), .reg_addr(), .reg_wdata(), .reg_we(),
    .reg_re(), .reg_rdata(reg_rdata), .pointer());
  twi_asserts #(.div(4)) u_twi_asserts (.clk(clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
    .scl_oe(bus.scl_oe), .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe));

  initial begin
    bus2.scl_o = 1'b0;
    bus2.sda_m_o = 1'b0;
    bus2.scl_oe = 1'b0;
    bus2.sda_m_oe = 1'b0;
    forever #20 clk = ~clk;
  end

  // Register file stand-in and watchdog
  always @(posedge clk) begin
    reg_rdata <= reg_addr ^ 8'h5a;
    cycles <= cycles + 1;
    if (reg_we === 1'b1) begin
      wr_n <= wr_n + 8'h01;
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
    end
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // Flags are start, stop, read
  task automatic send(input logic [2:0] f, input logic [7:0] d);
    cmd_valid <= 1'b1;
    {cmd_start, cmd_stop, cmd_read} <= f;
    cmd_data <= d;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge clk);
  endtask : send

  task automatic get(input logic [7:0] d, input logic a, input logic rd);
    rsp_ready <= 1'b1;
    do @(posedge clk); while (rsp_valid !== 1'b1);
    rsp_ready <= 1'b0;
    check(rd ? {16'h0, rsp_data} : {23'h0, rsp_ack}, rd ? {16'h0, d} : {23'h0, a}, "answer");
    @(posedge clk);
  endtask : get

  // Margin covers the slave's two-flop bus sampling
  task automatic wait_idle();
    do @(posedge clk); while (cmd_ready !== 1'b1);
    repeat (8) @(posedge clk);
  endtask : wait_idle

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Answers pile up while the receiver stalls
    send(3'h4, 8'h70);
    send(3'h0, 8'h05);
    repeat (500) @(posedge clk);
    check({23'h0, cmd_ready}, 24'h0, "ready while full");
    get(8'h00, 1'b1, 1'b0);
    get(8'h00, 1'b1, 1'b0);
    send(3'h0, 8'hab);
    get(8'h00, 1'b1, 1'b0);
    check({wr_n, wr_addr, wr_data}, 24'h0105ab, "first write");
    send(3'h2, 8'hcd);
    get(8'h00, 1'b1, 1'b0);
    wait_idle();
    check({wr_n, wr_addr, wr_data}, 24'h0206cd, "second write");
    check({16'h0, pointer}, 24'h000000, "wrap");
    // Command byte alone only moves the pointer
    send(3'h4, 8'h70);
    get(8'h00, 1'b1, 1'b0);
    send(3'h2, 8'h5b);
    get(8'h00, 1'b1, 1'b0);
    wait_idle();
    check({wr_n, 8'h00, pointer}, 24'h02005b, "pointer only");
    send(3'h4, 8'h71);
    get(8'h00, 1'b1, 1'b0);
    send(3'h3, 8'h00);
    get(8'h01, 1'b0, 1'b1);
    wait_idle();
    check({16'h0, pointer}, 24'h00005b, "last stays");
    for (int s = 0; s < 4; s++) begin
      address_strap_pin <= 2'(s);
      send(3'h6, {4'h7, 2'(s), 2'h0});
      get(8'h00, 1'b1, 1'b0);
      send(3'h6, {4'h7, ~2'(s), 2'h0});
      get(8'h00, 1'b0, 1'b0);
    end
    // Stalled clock on the second link: enabled, disabled, asleep
    for (int i = 0; i < 3; i++) begin
      {timeout_en, sleep} <= tmo_case[i][2:1];
      bus2.sda_m_oe <= 1'b1;
      repeat (4) @(posedge clk);
      bus2.scl_oe <= 1'b1;
      repeat (tmo + 40) @(posedge clk);
      check({23'h0, flag2}, {23'h0, tmo_case[i][0]}, "timeout flag");
      flag_read <= 1'b1;
      @(posedge clk);
      flag_read <= 1'b0;
      repeat (2) @(posedge clk);
      check({23'h0, flag2}, 24'h0, "flag cleared");
      bus2.scl_oe <= 1'b0;
      repeat (4) @(posedge clk);
      bus2.sda_m_oe <= 1'b0;
      repeat (8) @(posedge clk);
    end
    finish_test();
  end
endmodule : two_wire_slave_register_port_tb
